//--- hw/pwm_timer_pkg.sv
// Constants, field layout and mode decoding for the dual-slope PWM timer.
// Assumes a 32-bit APB register bus with byte addresses of eight bits.
package pwm_timer_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned CNT_W    = 16;
	localparam int unsigned CTRL_W   = 11;
	localparam int unsigned N_UNITS  = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_COMPARE_A   = 8'h04;
	localparam logic [7:0] OFS_COMPARE_B   = 8'h08;
	localparam logic [7:0] OFS_CAPTURE_TOP = 8'h0c;
	localparam logic [7:0] OFS_COUNTER     = 8'h10;
	localparam logic [7:0] OFS_FLAGS       = 8'h14;
	localparam logic [7:0] OFS_PORT        = 8'h18;

	// Control register fields
	localparam int unsigned WGS_LSB = 0;
	localparam int unsigned OMA_LSB = 4;
	localparam int unsigned OMB_LSB = 6;
	localparam int unsigned CS_LSB  = 8;

	// Flag bits
	localparam int unsigned FLAG_OVF  = 0;
	localparam int unsigned FLAG_CMPA = 1;
	localparam int unsigned FLAG_CMPB = 2;
	localparam int unsigned FLAG_CAP  = 3;

	// Port register bits: direction of pin A, B, then port data of A, B
	localparam int unsigned PORT_DIR_LSB  = 0;
	localparam int unsigned PORT_DATA_LSB = 2;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET    = 11'h000;
	localparam logic [CNT_W-1:0]  COMPARE_RESET = 16'h0000;
	localparam logic [CNT_W-1:0]  CAPTURE_RESET = 16'h0000;
	localparam logic [3:0]        PORT_RESET    = 4'h0;

	localparam logic [CNT_W-1:0] BOTTOM   = 16'h0000;
	localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00ff;
	localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01ff;
	localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03ff;

	// Wave generation selects handled here
	localparam logic [3:0] WGS_PC_8BIT   = 4'h1;
	localparam logic [3:0] WGS_PC_9BIT   = 4'h2;
	localparam logic [3:0] WGS_PC_10BIT  = 4'h3;
	localparam logic [3:0] WGS_PFC_CAP   = 4'h8;
	localparam logic [3:0] WGS_PFC_CMPA  = 4'h9;
	localparam logic [3:0] WGS_PC_CAP    = 4'ha;
	localparam logic [3:0] WGS_PC_CMPA   = 4'hb;

	// Output mode selects
	localparam logic [1:0] OMS_OFF    = 2'h0;
	localparam logic [1:0] OMS_TOGGLE = 2'h1;
	localparam logic [1:0] OMS_NONINV = 2'h2;
	localparam logic [1:0] OMS_INV    = 2'h3;

	// Prescale masks: tick when the free counter's low bits are all ones
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [9:0] MASK_DIV1    = 10'h000;
	localparam logic [9:0] MASK_DIV8    = 10'h007;
	localparam logic [9:0] MASK_DIV64   = 10'h03f;
	localparam logic [9:0] MASK_DIV256  = 10'h0ff;
	localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

	typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} count_dir_t;

	function automatic logic is_freq_correct(input logic [3:0] wgs);
		return (wgs == WGS_PFC_CAP) || (wgs == WGS_PFC_CMPA);
	endfunction

	function automatic logic is_dual_slope(input logic [3:0] wgs);
		return is_freq_correct(wgs) || (wgs == WGS_PC_8BIT) || (wgs == WGS_PC_9BIT) ||
			(wgs == WGS_PC_10BIT) || (wgs == WGS_PC_CAP) || (wgs == WGS_PC_CMPA);
	endfunction

	function automatic logic compare_a_is_top(input logic [3:0] wgs);
		return (wgs == WGS_PFC_CMPA) || (wgs == WGS_PC_CMPA);
	endfunction

	function automatic logic capture_is_top(input logic [3:0] wgs);
		return (wgs == WGS_PFC_CAP) || (wgs == WGS_PC_CAP);
	endfunction

endpackage

//--- hw/timer_bus_if.sv
// Carries the shared timebase from the prescaler to the counter core and from both to the compare units.
// Assumes one clock domain; all members are driven on clk_i.
`timescale 1ns/1ps
interface timer_bus_if;
	logic        tick;
	logic        run;
	logic [15:0] counter;
	logic        count_up;
	logic        load;

	modport prescale (output tick);
	modport core     (input tick, output run, output counter, output count_up, output load);
	modport unit     (input tick, input run, input counter, input count_up, input load);
endinterface

//--- hw/pwm_prescaler.sv
// Prescaler producing the one-cycle timer tick enable.
// Assumes the clock select is a register on the same clock.
`timescale 1ns/1ps
module pwm_prescaler (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [2:0] clk_sel_i,
	timer_bus_if.prescale   bus
);
	typedef struct packed {
		logic [9:0] div_cnt;
	} presc_state_t;

	presc_state_t s_q;
	presc_state_t s_d;
	logic         sel_ok;
	logic [9:0]   mask;

	function automatic logic [9:0] div_mask(input logic [2:0] sel);
		case (sel)
			pwm_timer_pkg::CS_DIV8:    return pwm_timer_pkg::MASK_DIV8;
			pwm_timer_pkg::CS_DIV64:   return pwm_timer_pkg::MASK_DIV64;
			pwm_timer_pkg::CS_DIV256:  return pwm_timer_pkg::MASK_DIV256;
			pwm_timer_pkg::CS_DIV1024: return pwm_timer_pkg::MASK_DIV1024;
			default:                   return pwm_timer_pkg::MASK_DIV1;
		endcase
	endfunction

	always_comb begin
		s_d         = s_q;
		s_d.div_cnt = s_q.div_cnt + 10'h001;
		sel_ok      = (clk_sel_i >= pwm_timer_pkg::CS_DIV1) && (clk_sel_i <= pwm_timer_pkg::CS_DIV1024);
		mask        = div_mask(clk_sel_i);
		// One tick per N clocks gives the 2*N*top period on the wave
		bus.tick    = sel_ok && ((s_q.div_cnt & mask) == mask);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- hw/pwm_compare_unit.sv
// One compare unit: buffered compare value, match detection and wave level.
// Assumes the core's load strobe marks the buffer update point of the mode.
`timescale 1ns/1ps
module pwm_compare_unit (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	timer_bus_if.unit        bus,
	input  wire logic [15:0] buffer_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic        toggle_ok_i,
	output logic [15:0]      active_o,
	output logic             match_o,
	output logic             wave_o,
	output logic             connected_o
);
	typedef struct packed {
		logic [15:0] active;
		logic        wave;
	} unit_state_t;

	unit_state_t s_q;
	unit_state_t s_d;

	always_comb begin
		s_d     = s_q;
		// Match only when the counter really reaches the value
		match_o = bus.tick && bus.run && (bus.counter == s_q.active);
		if (match_o) begin
			case (mode_i)
				pwm_timer_pkg::OMS_TOGGLE: if (toggle_ok_i) s_d.wave = ~s_q.wave;
				pwm_timer_pkg::OMS_NONINV: s_d.wave = ~bus.count_up;
				pwm_timer_pkg::OMS_INV:    s_d.wave = bus.count_up;
				default: ;
			endcase
		end
		if (bus.load) begin
			s_d.active = buffer_i;
		end
		active_o    = s_q.active;
		wave_o      = s_q.wave;
		connected_o = (mode_i == pwm_timer_pkg::OMS_NONINV) || (mode_i == pwm_timer_pkg::OMS_INV) ||
			((mode_i == pwm_timer_pkg::OMS_TOGGLE) && toggle_ok_i);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '{active: pwm_timer_pkg::COMPARE_RESET, wave: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- hw/dual_slope_pwm_timer.sv
// Top of the dual-slope PWM timer: APB registers, up/down counter, flags and pins.
// Assumes an APB master on clk_i and pins resolved outside from output and enable.
// How it works
// - Phase correct: old top down, new top up
// - Mode two non-inverted, three inverted
// - Pin driven only when direction is output
// - Clear on up match, set on down
// - Period is two times divisor times top
// - Phase correct: zero low, top high
// - Frequency correct: zero low, top high
// - Select 11 toggle mode gives square wave
// - Select 9 toggle mode gives square wave
// - Selects 8 and 9 count zero-top-zero
// - Top from capture or compare A, once
// - Frequency correct loads compares at zero
// - Overflow flag with the load at zero
// - Top source flag sets at top
// - Match flag when counter equals compare
// - Tick is only an enable, one clock
// - Selects 1,2,3,10,11 are phase correct
// - Phase correct: overflow at zero, load at top
// - Capture top takes effect at once
// - Mode zero leaves pin to port
`timescale 1ns/1ps
module dual_slope_pwm_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             wave_out_a_o,
	output logic             wave_out_a_oe_b_o,
	output logic             wave_out_b_o,
	output logic             wave_out_b_oe_b_o
);
	typedef struct packed {
		logic [10:0]               ctrl;
		logic [15:0]               cmp_a_buf;
		logic [15:0]               cmp_b_buf;
		logic [15:0]               capture_top;
		logic [15:0]               counter;
		pwm_timer_pkg::count_dir_t dir;
		logic [3:0]                flags;
		logic [3:0]                port;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
		logic [1:0]                pin;
		logic [1:0]                pin_oe_b;
	} top_state_t;

	top_state_t  s_q;
	top_state_t  s_d;

	timer_bus_if bus ();

	logic [3:0]  wgs;
	logic [15:0] top;
	logic        dual;
	logic        at_top;
	logic        at_bottom;
	logic        setup;
	logic        access;
	logic        wr;
	logic [3:0]  set;
	logic [3:0]  clear;
	logic [15:0] buffer   [2];
	logic [1:0]  mode     [2];
	logic [1:0]  toggle_ok;
	logic [15:0] active   [2];
	logic [1:0]  match;
	logic [1:0]  wave;
	logic [1:0]  connected;

	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			pwm_timer_pkg::OFS_CTRL, pwm_timer_pkg::OFS_COMPARE_A, pwm_timer_pkg::OFS_COMPARE_B,
			pwm_timer_pkg::OFS_CAPTURE_TOP, pwm_timer_pkg::OFS_COUNTER, pwm_timer_pkg::OFS_FLAGS,
			pwm_timer_pkg::OFS_PORT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] read_mux(input top_state_t s, input logic [7:0] a);
		case (a)
			pwm_timer_pkg::OFS_CTRL:        return {21'h000000, s.ctrl};
			pwm_timer_pkg::OFS_COMPARE_A:   return {16'h0000, s.cmp_a_buf};
			pwm_timer_pkg::OFS_COMPARE_B:   return {16'h0000, s.cmp_b_buf};
			pwm_timer_pkg::OFS_CAPTURE_TOP: return {16'h0000, s.capture_top};
			pwm_timer_pkg::OFS_COUNTER:     return {16'h0000, s.counter};
			pwm_timer_pkg::OFS_FLAGS:       return {28'h0000000, s.flags};
			pwm_timer_pkg::OFS_PORT:        return {28'h0000000, s.port};
			default:                        return 32'h00000000;
		endcase
	endfunction

	// Top of the running mode; compare A as top uses its active copy
	function automatic logic [15:0] top_of(input logic [3:0] w, input logic [15:0] a_act,
		input logic [15:0] cap);
		case (w)
			pwm_timer_pkg::WGS_PC_8BIT:  return pwm_timer_pkg::TOP_8BIT;
			pwm_timer_pkg::WGS_PC_9BIT:  return pwm_timer_pkg::TOP_9BIT;
			pwm_timer_pkg::WGS_PC_10BIT: return pwm_timer_pkg::TOP_10BIT;
			pwm_timer_pkg::WGS_PFC_CAP,
			pwm_timer_pkg::WGS_PC_CAP:   return cap;
			pwm_timer_pkg::WGS_PFC_CMPA,
			pwm_timer_pkg::WGS_PC_CMPA:  return a_act;
			default:                     return pwm_timer_pkg::TOP_8BIT;
		endcase
	endfunction

	pwm_prescaler u_prescaler (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.clk_sel_i (s_q.ctrl[pwm_timer_pkg::CS_LSB +: 3]),
		.bus       (bus.prescale)
	);

	assign buffer[0]    = s_q.cmp_a_buf;
	assign buffer[1]    = s_q.cmp_b_buf;
	assign mode[0]      = s_q.ctrl[pwm_timer_pkg::OMA_LSB +: 2];
	assign mode[1]      = s_q.ctrl[pwm_timer_pkg::OMB_LSB +: 2];
	// Toggling is only offered on unit A while compare A sets the top
	assign toggle_ok[0] = pwm_timer_pkg::compare_a_is_top(wgs);
	assign toggle_ok[1] = 1'b0;

	generate
		for (genvar u = 0; u < pwm_timer_pkg::N_UNITS; u++) begin : g_unit
			pwm_compare_unit u_compare (
				.clk_i       (clk_i),
				.rst_b_i     (rst_b_i),
				.bus         (bus.unit),
				.buffer_i    (buffer[u]),
				.mode_i      (mode[u]),
				.toggle_ok_i (toggle_ok[u]),
				.active_o    (active[u]),
				.match_o     (match[u]),
				.wave_o      (wave[u]),
				.connected_o (connected[u])
			);
		end
	endgenerate

	always_comb begin
		s_d       = s_q;
		wgs       = s_q.ctrl[pwm_timer_pkg::WGS_LSB +: 4];
		dual      = pwm_timer_pkg::is_dual_slope(wgs);
		top       = top_of(wgs, active[0], s_q.capture_top);
		at_top    = (s_q.counter == top);
		at_bottom = (s_q.counter == pwm_timer_pkg::BOTTOM);

		// Direction of the step about to be taken; it reverses at either end
		if (at_bottom) begin
			bus.count_up = 1'b1;
		end else if (at_top) begin
			bus.count_up = 1'b0;
		end else begin
			bus.count_up = (s_q.dir == pwm_timer_pkg::DIR_UP);
		end
		bus.run     = dual;
		bus.counter = s_q.counter;
		// Compares reload at zero in frequency correct, at top in phase correct
		// Outside the dual-slope modes the compare buffer passes straight through
		if (!dual) begin
			bus.load = 1'b1;
		end else if (pwm_timer_pkg::is_freq_correct(wgs)) begin
			bus.load = bus.tick && at_bottom;
		end else begin
			bus.load = bus.tick && at_top;
		end

		// Counter moves only on a tick; other clocks hold count and direction
		// A top lowered under the count lets it run on and wrap through zero
		if (bus.tick && dual) begin
			if (bus.count_up) begin
				s_d.dir     = pwm_timer_pkg::DIR_UP;
				s_d.counter = s_q.counter + 16'h0001;
			end else begin
				s_d.dir     = pwm_timer_pkg::DIR_DOWN;
				s_d.counter = s_q.counter - 16'h0001;  // Top is held for exactly one tick
			end
		end

		// Flag events, all sampled on a tick
		set                          = 4'h0;
		set[pwm_timer_pkg::FLAG_OVF] = bus.tick && dual && at_bottom;
		set[pwm_timer_pkg::FLAG_CMPA] = match[0] ||
			(bus.tick && dual && at_top && pwm_timer_pkg::compare_a_is_top(wgs));
		set[pwm_timer_pkg::FLAG_CMPB] = match[1];
		set[pwm_timer_pkg::FLAG_CAP]  =
			bus.tick && dual && at_top && pwm_timer_pkg::capture_is_top(wgs);

		// APB: setup registers the answer, so the access phase never waits
		setup     = psel_i && !penable_i;
		access    = psel_i && penable_i && s_q.pready;
		wr        = access && pwrite_i && !s_q.pslverr;
		s_d.pready = setup;
		if (setup) begin
			s_d.pslverr = !addr_mapped(paddr_i);
			s_d.prdata  = pwrite_i ? 32'h00000000 : read_mux(s_q, paddr_i);
		end else if (access) begin
			s_d.pslverr = 1'b0;
			s_d.prdata  = 32'h00000000;
		end

		clear = (wr && (paddr_i == pwm_timer_pkg::OFS_FLAGS)) ? pwdata_i[3:0] : 4'h0;
		// A flag event in the clearing cycle survives
		s_d.flags = (s_q.flags & ~clear) | set;

		if (wr) begin
			case (paddr_i)
				pwm_timer_pkg::OFS_CTRL:        s_d.ctrl        = pwdata_i[10:0];
				pwm_timer_pkg::OFS_COMPARE_A:   s_d.cmp_a_buf   = pwdata_i[15:0];
				pwm_timer_pkg::OFS_COMPARE_B:   s_d.cmp_b_buf   = pwdata_i[15:0];
				pwm_timer_pkg::OFS_CAPTURE_TOP: s_d.capture_top = pwdata_i[15:0];
				pwm_timer_pkg::OFS_COUNTER:     s_d.counter     = pwdata_i[15:0];
				pwm_timer_pkg::OFS_PORT:        s_d.port        = pwdata_i[3:0];
				default: ;
			endcase
		end

		// Pins: wave overrides port data when connected; driven only as outputs
		for (int u = 0; u < 2; u++) begin
			s_d.pin[u]      = connected[u] ? wave[u] : s_q.port[pwm_timer_pkg::PORT_DATA_LSB + u];
			s_d.pin_oe_b[u] = !s_q.port[pwm_timer_pkg::PORT_DIR_LSB + u];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q.ctrl        <= pwm_timer_pkg::CTRL_RESET;
			s_q.cmp_a_buf   <= pwm_timer_pkg::COMPARE_RESET;
			s_q.cmp_b_buf   <= pwm_timer_pkg::COMPARE_RESET;
			s_q.capture_top <= pwm_timer_pkg::CAPTURE_RESET;
			s_q.counter     <= pwm_timer_pkg::BOTTOM;
			s_q.dir         <= pwm_timer_pkg::DIR_UP;
			s_q.flags       <= 4'h0;
			s_q.port        <= pwm_timer_pkg::PORT_RESET;
			s_q.pready      <= 1'b0;
			s_q.pslverr     <= 1'b0;
			s_q.prdata      <= 32'h00000000;
			s_q.pin         <= 2'h0;
			s_q.pin_oe_b    <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata_o          = s_q.prdata;
	assign pready_o          = s_q.pready;
	assign pslverr_o         = s_q.pslverr;
	assign wave_out_a_o      = s_q.pin[0];
	assign wave_out_a_oe_b_o = s_q.pin_oe_b[0];
	assign wave_out_b_o      = s_q.pin[1];
	assign wave_out_b_oe_b_o = s_q.pin_oe_b[1];
endmodule

//--- test/dual_slope_pwm_timer_asserts.sv
// Checker for the dual-slope PWM timer top: APB answer timing, decode and pin control.
// Assumes it is bound to dual_slope_pwm_timer and sees only that module's ports.
`timescale 1ns/1ps
module dual_slope_pwm_timer_asserts (
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        wave_out_a_o,
	input wire logic        wave_out_a_oe_b_o,
	input wire logic        wave_out_b_o,
	input wire logic        wave_out_b_oe_b_o
);
	logic       wr;
	logic [3:0] port_q;
	logic [3:0] om_q;
	logic [1:0] quiet_q;

	assign wr = psel_i && penable_i && pready_o && pwrite_i;

	// Pins lag the registers, so they are judged only once control has settled
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_q  <= 4'h0;
			om_q    <= 4'h0;
			quiet_q <= 2'h0;
		end else if (wr && paddr_i == 8'h18) begin
			port_q  <= pwdata_i[3:0];
			quiet_q <= 2'h0;
		end else if (wr && paddr_i == 8'h00) begin
			om_q    <= pwdata_i[7:4];
			quiet_q <= 2'h0;
		end else if (quiet_q != 2'h3) begin
			quiet_q <= quiet_q + 2'h1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	a_idle_no_ready: assert property (!psel_i |=> !pready_o)
		else $error("ready without setup");
	a_err_decode: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h18 || paddr_i[1:0] != 2'h0))
		else $error("error response disagrees with address");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error outside access");
	a_write_reads_zero: assert property (pready_o && pwrite_i |-> prdata_o == 32'h0)
		else $error("read data on write");
	a_oe_a_dir: assert property (quiet_q == 2'h3 |-> wave_out_a_oe_b_o == !port_q[0])
		else $error("pin A enable wrong");
	a_oe_b_dir: assert property (quiet_q == 2'h3 |-> wave_out_b_oe_b_o == !port_q[1])
		else $error("pin B enable wrong");
	a_pin_a_port: assert property (quiet_q == 2'h3 && om_q[1:0] == 2'h0 |-> wave_out_a_o == port_q[2])
		else $error("pin A not under port control");
	a_pin_b_port: assert property (quiet_q == 2'h3 && om_q[3:2] == 2'h0 |-> wave_out_b_o == port_q[3])
		else $error("pin B not under port control");

	c_port_write: cover property (wr && paddr_i == 8'h18);
	c_unmapped: cover property (pslverr_o);
	c_wave_rise: cover property (om_q[1:0] == 2'h2 && !wave_out_a_oe_b_o && $rose(wave_out_a_o));
endmodule

bind dual_slope_pwm_timer dual_slope_pwm_timer_asserts i_chk (
	.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
	.pslverr_o, .wave_out_a_o, .wave_out_a_oe_b_o, .wave_out_b_o, .wave_out_b_oe_b_o
);

//--- test/dual_slope_pwm_timer_tb.sv
// Self-checking bench for the dual-slope PWM timer: registers, waveform timing, flags, pins.
// Assumes the checker binds itself from its own file; clock is 200 MHz.
`timescale 1ns/1ps
module dual_slope_pwm_timer_tb;
	typedef struct packed {
		logic [3:0]  wgs;
		logic [1:0]  om;
		logic [2:0]  cs;
		logic [15:0] top;
		logic [15:0] cmp;
	} row_t;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        perr;
	logic        wa;
	logic        wa_oe_b;
	logic        wb;
	logic        wb_oe_b;
	logic [31:0] rd;
	logic        err;
	logic        ok;
	int          bad_count = 0;
	int          total_checks = 0;
	int          hi;
	int          lo;
	int          n;
	int          eh;
	int          el;
	row_t        r;
	int          dv [6] = '{0, 1, 8, 64, 256, 1024};
	row_t        rows [12] = '{
		'{4'h8, 2'h2, 3'h1, 16'h000a, 16'h0004}, '{4'h8, 2'h3, 3'h1, 16'h000a, 16'h0004},
		'{4'ha, 2'h2, 3'h1, 16'h000a, 16'h0003}, '{4'ha, 2'h3, 3'h2, 16'h0005, 16'h0002},
		'{4'h8, 2'h2, 3'h3, 16'h0003, 16'h0001}, '{4'ha, 2'h2, 3'h4, 16'h0003, 16'h0002},
		'{4'h8, 2'h2, 3'h5, 16'h0003, 16'h0001}, '{4'h9, 2'h1, 3'h1, 16'h0006, 16'h0006},
		'{4'hb, 2'h1, 3'h1, 16'h0005, 16'h0005}, '{4'h1, 2'h2, 3'h1, 16'h00ff, 16'h0040},
		'{4'h2, 2'h3, 3'h1, 16'h01ff, 16'h0100}, '{4'h3, 2'h2, 3'h1, 16'h03ff, 16'h0010}};

	dual_slope_pwm_timer i_dut (
		.clk_i             (clk),
		.rst_b_i           (rst_b),
		.psel_i            (psel),
		.penable_i         (pen),
		.pwrite_i          (pwr),
		.paddr_i           (paddr),
		.pwdata_i          (pwdata),
		.prdata_o          (prdata),
		.pready_o          (pready),
		.pslverr_o         (perr),
		.wave_out_a_o      (wa),
		.wave_out_a_oe_b_o (wa_oe_b),
		.wave_out_b_o      (wb),
		.wave_out_b_oe_b_o (wb_oe_b)
	);

	always #2.5 clk = ~clk;

	task automatic end_sim();
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One idle edge before each setup, so strobes are never driven twice in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	// Stop first: in a non dual-slope select the compares load at once and the counter holds
	// Top is only moved while stopped, so neither dual-slope mode sees a running top change
	task automatic cfg(input row_t c);
		xfer(1'b1, 8'h00, 32'h0);
		xfer(1'b1, 8'h10, 32'h0);
		xfer(1'b1, 8'h0c, {16'h0, c.top});
		xfer(1'b1, 8'h04, {16'h0, c.cmp});
		xfer(1'b1, 8'h00, {21'h0, c.cs, 2'h0, c.om, c.wgs});
	endtask

	task automatic meas(output int h, output int l);
		int k;
		k = 0;
		h = 0;
		l = 0;
		while (wa !== 1'b0 && k < 20000) begin
			@(posedge clk);
			k++;
		end
		while (wa !== 1'b1 && k < 20000) begin
			@(posedge clk);
			k++;
		end
		while (wa === 1'b1 && k < 20000) begin
			@(posedge clk);
			k++;
			h++;
		end
		while (wa === 1'b0 && k < 20000) begin
			@(posedge clk);
			k++;
			l++;
		end
	endtask

	initial begin
		#(95000 * 5);
		bad_count++;
		end_sim();
	end

	initial begin
		repeat (16) @(posedge clk);
		check({pready, wa_oe_b, wb_oe_b}, 3'h3);
		rst_b <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0);
			check(rd, 32'h0);
		end
		xfer(1'b0, 8'h1c, 32'h0);
		check({err, rd[3:0]}, 5'h10);
		xfer(1'b1, 8'h18, 32'h3);
		repeat (4) @(posedge clk);
		check({wa_oe_b, wb_oe_b}, 2'h0);
		foreach (rows[i]) begin
			r = rows[i];
			cfg(r);
			n = 2 * dv[r.cs];
			eh = (r.om == 2'h1) ? r.top : ((r.om == 2'h2) ? r.cmp : r.top - r.cmp);
			el = (r.om == 2'h1) ? r.top : r.top - eh;
			meas(hi, lo);
			meas(hi, lo);
			check(hi, n * eh);
			check(lo, n * el);
		end
		for (int k = 0; k < 8; k++) begin
			r = '{k[2] ? 4'ha : 4'h8, k[1] ? 2'h3 : 2'h2, 3'h1, 16'h0008, k[0] ? 16'h0008 : 16'h0000};
			cfg(r);
			repeat (40) @(posedge clk);
			ok = 1'b1;
			repeat (40) begin
				@(posedge clk);
				if (wa !== (k[0] ^ k[1])) ok = 1'b0;
			end
			check(ok, 1'b1);
		end
		for (int k = 0; k < 2; k++) begin
			r = '{k ? 4'ha : 4'h8, 2'h2, 3'h0, 16'h000a, 16'h0004};
			xfer(1'b1, 8'h08, 32'h20);
			cfg(r);
			xfer(1'b1, 8'h14, 32'hf);
			xfer(1'b1, 8'h00, {21'h0, 3'h1, 4'h2, r.wgs});
			repeat (40) @(posedge clk);
			xfer(1'b1, 8'h00, {21'h0, 3'h0, 4'h2, r.wgs});
			xfer(1'b0, 8'h14, 32'h0);
			check(rd, 32'hb);
			xfer(1'b1, 8'h14, 32'h1);
			xfer(1'b0, 8'h14, 32'h0);
			check(rd, 32'ha);
		end
		xfer(1'b1, 8'h10, 32'h5);
		xfer(1'b1, 8'h00, {21'h0, 3'h6, 4'h2, 4'h8});
		repeat (20) @(posedge clk);
		xfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'h5);
		r = '{4'h8, 2'h0, 3'h1, 16'h000a, 16'h0004};
		cfg(r);
		xfer(1'b1, 8'h18, 32'hf);
		repeat (4) @(posedge clk);
		check({wa, wb, wa_oe_b, wb_oe_b}, 4'hc);
		xfer(1'b1, 8'h18, 32'h4);
		repeat (4) @(posedge clk);
		check({wa, wb, wa_oe_b, wb_oe_b}, 4'hb);
		// Second reset in mid-run: pins released, registers back to zero
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		check({wa, pready, wa_oe_b, wb_oe_b}, 4'h3);
		rst_b <= 1'b1;
		xfer(1'b0, 8'h18, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, 8'h00, 32'h0);
		check(rd, 32'h0);
		end_sim();
	end
endmodule
